/* File: logic/tpc_cfg.svh */
// constants for the timer/pwm configuration and pin routing block
// Overview of operation
// R1: control bit 0 clear holds timer reset
// R2: control bit 2 starts or stops counting
// R3: bits 5:4 pick falling, rising, both edges
// R4: bit 6 picks stop or edge interrupt
// R5: bit 7 picks timer or pwm mode
// R6: prescaler divides master clock by 2^n
// R7: prescaler bit 5 picks pulse or square
// R8: port A bits 0-2 route timer outputs
// R9: port A bit 3 sets 7 or 8 bits
// R10: port C bits 0-2 clear route timers
// R11: port C bit 3 clear routes serial transmit
// R12: pwm output falls at compare, holds low
// R13: reload loads whenever counter restarts counting
// R14: unused bits ignore writes, read zero
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH

// register byte offsets on the bus
`define TPC_OFS_T1_CTRL 8'h00
`define TPC_OFS_T1_PRESC 8'h04
`define TPC_OFS_T2_CTRL 8'h08
`define TPC_OFS_T2_PRESC 8'h0c
`define TPC_OFS_PA_ROUTE 8'h10
`define TPC_OFS_PC_ROUTE 8'h14
`define TPC_OFS_T1_RELOAD 8'h18
`define TPC_OFS_T1_COMPARE 8'h1c
`define TPC_OFS_T2_RELOAD 8'h20
`define TPC_OFS_T2_COMPARE 8'h24
`define TPC_OFS_IRQ_STAT 8'h28
`define TPC_OFS_IRQ_MASK 8'h2c
`define TPC_OFS_T_STATE 8'h30

// control register fields
`define TPC_CTL_RST_N 0
`define TPC_CTL_RUN 2
`define TPC_CTL_EDGE_LO 4
`define TPC_CTL_EDGE_HI 5
`define TPC_CTL_SRC 6
`define TPC_CTL_PWM 7
// prescale register fields
`define TPC_PRE_CODE_HI 4
`define TPC_PRE_SQUARE 5
// routing register fields
`define TPC_RT_T0 0
`define TPC_RT_T1 1
`define TPC_RT_T2 2
`define TPC_RT_B3 3

// writable bits of each register
`define TPC_MASK_CTRL 8'hf5
`define TPC_MASK_PRESC 8'h3f
`define TPC_MASK_ROUTE 8'h0f
`define TPC_MASK_IRQ 8'h03

// reset values
`define TPC_RST_CTRL 8'h00
`define TPC_RST_PRESC 8'h00
`define TPC_RST_PA 8'h00
`define TPC_RST_PC 8'h0f
`define TPC_RST_RELOAD 8'h00
`define TPC_RST_COMPARE 8'h80

// largest prescaler code, divide by 65536
`define TPC_DIV_CODE_MAX 5'h10

`endif

/* File: logic/tpc_pkg.sv */
// types shared by the timer/pwm configuration block
package tpc_pkg;
  // interrupt edge choices of the two-bit edge field
  typedef enum logic [1:0] {
    TPC_EDGE_FALL = 2'h0,
    TPC_EDGE_RISE = 2'h1,
    TPC_EDGE_BOTH = 2'h2,
    TPC_EDGE_RSVD = 2'h3
  } tpc_edge_type;
  // bus slave phase
  typedef enum logic {
    TPC_BUS_IDLE,
    TPC_BUS_ACK
  } tpc_bus_type;
endpackage : tpc_pkg

/* File: logic/tpc_timer.sv */
// one 8-bit timer/pwm channel with its power-of-two prescaler
`timescale 1ns/1ns
`include "tpc_cfg.svh"
module tpc_timer #(
  parameter int CNT_W = 8,
  parameter int PRE_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic soft_reset_n,
  input wire logic soft_run,
  input wire logic pwm_select,
  input wire logic square_wave_sel,
  input wire logic [4:0] clock_divider_code,
  input wire logic [CNT_W-1:0] reload,
  input wire logic [CNT_W-1:0] compare,
  output logic wave_q,
  output logic running_q,
  output logic stop_q,
  output logic [CNT_W-1:0] count_q
);
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  // low bits of the prescaler that must all be one for a tick
  function automatic logic [PRE_W-1:0] div_mask(input logic [4:0] code);
    logic [PRE_W-1:0] m;
    m = '0;
    for (int i = 0; i < PRE_W; i++) begin
      if (i < int'(code)) m[i] = 1'b1;
    end
    return m;
  endfunction

  logic [PRE_W-1:0] pre_q; // free prescaler count
  logic [PRE_W-1:0] mask; // active divider bits
  logic tick; // one counter step
  logic start; // run rising out of reset
  logic cnt_end; // counter at its turn point
  logic pwm_hi0; // pwm level at cycle start

  assign mask = div_mask(clock_divider_code);
  assign tick = running_q && ((pre_q & mask) == mask);
  assign start = soft_reset_n && soft_run && !running_q;
  assign cnt_end = pwm_select ? (count_q == CNT_MAX) : (count_q == compare);
  // compare of all ones stays high, below reload stays low
  assign pwm_hi0 = (compare == CNT_MAX) || (compare > reload);

  // prescaler, cleared whenever the counter is not running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= '0;
    end else if (ce) begin
      if (!running_q) pre_q <= '0; // R6
      else pre_q <= pre_q + 1'b1; // R6
    end
  end

  // run state and stop event
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      running_q <= 1'b0;
      stop_q <= 1'b0;
    end else if (ce) begin
      running_q <= soft_reset_n && soft_run; // R1 R2
      stop_q <= running_q && !(soft_reset_n && soft_run); // R4
    end
  end

  // counter and output waveform
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      wave_q <= 1'b0;
    end else if (ce) begin
      if (!soft_reset_n) begin
        // held in internal reset
        count_q <= reload; // R1
        wave_q <= 1'b0; // R1
      end else if (start) begin
        count_q <= reload; // R13
        wave_q <= pwm_select ? pwm_hi0 : wave_q; // R5 R12
      end else if (tick) begin
        if (cnt_end) begin
          count_q <= reload; // R13
          if (pwm_select) wave_q <= pwm_hi0; // R5
          else if (square_wave_sel) wave_q <= !wave_q; // R7
          else wave_q <= 1'b1; // R7
        end else begin
          count_q <= count_q + 1'b1;
          if (pwm_select) begin
            // falls at compare and stays low to the cycle end
            if ((count_q + 1'b1) == compare && compare != CNT_MAX)
              wave_q <= 1'b0; // R12
          end else if (!square_wave_sel) begin
            wave_q <= 1'b0; // R7
          end
        end
      end
    end
  end
endmodule // tpc_timer

/* File: logic/tpc_top.sv */
// timer/pwm configuration registers, two channels and pin routing
`timescale 1ns/1ns
`include "tpc_cfg.svh"
module tpc_top #(
  parameter int CNT_W = 8,
  parameter int PRE_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // first timer output from outside this block
  input wire logic timer_a_pin_out,
  // serial transmitter output
  input wire logic sci_tx_out,
  // general purpose port data and enables
  input wire logic [7:0] gpio_a_out,
  input wire logic [7:0] gpio_a_oe,
  input wire logic [3:0] gpio_c_out,
  input wire logic [3:0] gpio_c_oe,
  // port pins
  output logic [7:0] porta_pin_out,
  output logic [7:0] porta_pin_oe,
  output logic [3:0] portc_pin_out,
  output logic [3:0] portc_pin_oe,
  // channel outputs and interrupt
  output logic timer_b_wave_out,
  output logic timer_c_wave_out,
  output logic irq_q
);
  // reset release synchroniser
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // configuration registers
  logic [7:0] t1_ctrl_q; // timer1 control
  logic [7:0] t1_presc_q; // timer1 prescale and wave
  logic [7:0] t2_ctrl_q; // timer2 control
  logic [7:0] t2_presc_q; // timer2 prescale and wave
  logic [7:0] pa_route_q; // port a routing
  logic [7:0] pc_route_q; // port c routing
  logic [CNT_W-1:0] t1_reload_q; // timer1 reload
  logic [CNT_W-1:0] t1_compare_q; // timer1 compare
  logic [CNT_W-1:0] t2_reload_q; // timer2 reload
  logic [CNT_W-1:0] t2_compare_q; // timer2 compare
  logic [1:0] irq_stat_q; // sticky events
  logic [1:0] irq_mask_q; // event enables
  tpc_pkg::tpc_bus_type bus_q; // slave phase

  // named fields
  wire t1_soft_reset_n = t1_ctrl_q[`TPC_CTL_RST_N];
  wire t1_soft_run = t1_ctrl_q[`TPC_CTL_RUN];
  wire [1:0] t1_irq_edge_sel = t1_ctrl_q[`TPC_CTL_EDGE_HI:`TPC_CTL_EDGE_LO];
  wire t1_irq_source_sel = t1_ctrl_q[`TPC_CTL_SRC];
  wire t1_pwm_select = t1_ctrl_q[`TPC_CTL_PWM];
  wire [4:0] t1_clock_divider_code = t1_presc_q[`TPC_PRE_CODE_HI:0];
  wire t1_square_wave_sel = t1_presc_q[`TPC_PRE_SQUARE];
  wire t2_soft_reset_n = t2_ctrl_q[`TPC_CTL_RST_N];
  wire t2_soft_run = t2_ctrl_q[`TPC_CTL_RUN];
  wire [1:0] t2_irq_edge_sel = t2_ctrl_q[`TPC_CTL_EDGE_HI:`TPC_CTL_EDGE_LO];
  wire t2_irq_source_sel = t2_ctrl_q[`TPC_CTL_SRC];
  wire t2_pwm_select = t2_ctrl_q[`TPC_CTL_PWM];
  wire [4:0] t2_clock_divider_code = t2_presc_q[`TPC_PRE_CODE_HI:0];
  wire t2_square_wave_sel = t2_presc_q[`TPC_PRE_SQUARE];
  wire porta_pin1_timer_route = pa_route_q[`TPC_RT_T0];
  wire porta_pin2_timer_route = pa_route_q[`TPC_RT_T1];
  wire porta_pin3_timer_route = pa_route_q[`TPC_RT_T2];
  wire porta_width_sel = pa_route_q[`TPC_RT_B3];
  wire portc_pin1_gpio_sel = pc_route_q[`TPC_RT_T0];
  wire portc_pin2_gpio_sel = pc_route_q[`TPC_RT_T1];
  wire portc_pin3_gpio_sel = pc_route_q[`TPC_RT_T2];
  wire portc_pin4_gpio_sel = pc_route_q[`TPC_RT_B3];

  // prescaler codes above the largest divide as the largest
  function automatic logic [4:0] clamp_code(input logic [7:0] v);
    logic [4:0] c;
    c = v[`TPC_PRE_CODE_HI:0];
    if (c > `TPC_DIV_CODE_MAX) c = `TPC_DIV_CODE_MAX;
    return c;
  endfunction

  // pick the interrupt event from source and edge fields
  function automatic logic irq_event(input logic src, input logic [1:0] sel,
                                     input logic rise, input logic fall,
                                     input logic stop);
    logic e;
    e = 1'b0;
    if (!src) begin
      e = stop; // R4
    end else begin
      unique case (tpc_pkg::tpc_edge_type'(sel))
        tpc_pkg::TPC_EDGE_FALL: e = fall; // R3
        tpc_pkg::TPC_EDGE_RISE: e = rise; // R3
        tpc_pkg::TPC_EDGE_BOTH: e = rise | fall; // R3
        tpc_pkg::TPC_EDGE_RSVD: e = 1'b0; // R3
      endcase
    end
    return e;
  endfunction

  // bus decode
  logic bus_req; // request waiting for its answer
  logic bus_wr; // write taken this cycle
  logic [7:0] wdat; // low write byte
  assign bus_req = wb_cyc_i && wb_stb_i && (bus_q == tpc_pkg::TPC_BUS_IDLE);
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  assign wdat = wb_dat_i[7:0];

  // one cycle answer, dropped the cycle after
  always_ff @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      bus_q <= tpc_pkg::TPC_BUS_IDLE;
      wb_ack_o <= 1'b0;
    end else if (clk_en) begin
      if (bus_req) begin
        bus_q <= tpc_pkg::TPC_BUS_ACK;
        wb_ack_o <= 1'b1;
      end else begin
        bus_q <= tpc_pkg::TPC_BUS_IDLE;
        wb_ack_o <= 1'b0;
      end
    end
  end

  // timer control and prescale registers
  always_ff @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      t1_ctrl_q <= `TPC_RST_CTRL;
      t1_presc_q <= `TPC_RST_PRESC;
      t2_ctrl_q <= `TPC_RST_CTRL;
      t2_presc_q <= `TPC_RST_PRESC;
    end else if (clk_en && bus_wr) begin
      unique case (wb_adr_i)
        `TPC_OFS_T1_CTRL: t1_ctrl_q <= wdat & `TPC_MASK_CTRL; // R14
        `TPC_OFS_T1_PRESC: t1_presc_q <= wdat & `TPC_MASK_PRESC; // R14
        `TPC_OFS_T2_CTRL: t2_ctrl_q <= wdat & `TPC_MASK_CTRL; // R14
        `TPC_OFS_T2_PRESC: t2_presc_q <= wdat & `TPC_MASK_PRESC; // R14
        default: ;
      endcase
    end
  end

  // routing registers
  always_ff @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pa_route_q <= `TPC_RST_PA;
      pc_route_q <= `TPC_RST_PC;
    end else if (clk_en && bus_wr) begin
      if (wb_adr_i == `TPC_OFS_PA_ROUTE)
        pa_route_q <= wdat & `TPC_MASK_ROUTE; // R14
      if (wb_adr_i == `TPC_OFS_PC_ROUTE)
        pc_route_q <= wdat & `TPC_MASK_ROUTE; // R14
    end
  end

  // reload and compare values
  always_ff @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      t1_reload_q <= `TPC_RST_RELOAD;
      t1_compare_q <= `TPC_RST_COMPARE;
      t2_reload_q <= `TPC_RST_RELOAD;
      t2_compare_q <= `TPC_RST_COMPARE;
    end else if (clk_en && bus_wr) begin
      unique case (wb_adr_i)
        `TPC_OFS_T1_RELOAD: t1_reload_q <= wdat;
        `TPC_OFS_T1_COMPARE: t1_compare_q <= wdat;
        `TPC_OFS_T2_RELOAD: t2_reload_q <= wdat;
        `TPC_OFS_T2_COMPARE: t2_compare_q <= wdat;
        default: ;
      endcase
    end
  end

  // the two channels
  logic t1_wave;
  logic t1_run;
  logic t1_stop;
  logic [CNT_W-1:0] t1_count;
  logic t2_wave;
  logic t2_run;
  logic t2_stop;
  logic [CNT_W-1:0] t2_count;

  tpc_timer #(.CNT_W(CNT_W), .PRE_W(PRE_W)) u_t1 (
    .clk(ref_clk),
    .rst_n(rst_sync_q),
    .ce(clk_en),
    .soft_reset_n(t1_soft_reset_n),
    .soft_run(t1_soft_run),
    .pwm_select(t1_pwm_select),
    .square_wave_sel(t1_square_wave_sel),
    .clock_divider_code(clamp_code(t1_presc_q)),
    .reload(t1_reload_q),
    .compare(t1_compare_q),
    .wave_q(t1_wave),
    .running_q(t1_run),
    .stop_q(t1_stop),
    .count_q(t1_count)
  );

  tpc_timer #(.CNT_W(CNT_W), .PRE_W(PRE_W)) u_t2 (
    .clk(ref_clk),
    .rst_n(rst_sync_q),
    .ce(clk_en),
    .soft_reset_n(t2_soft_reset_n),
    .soft_run(t2_soft_run),
    .pwm_select(t2_pwm_select),
    .square_wave_sel(t2_square_wave_sel),
    .clock_divider_code(clamp_code(t2_presc_q)),
    .reload(t2_reload_q),
    .compare(t2_compare_q),
    .wave_q(t2_wave),
    .running_q(t2_run),
    .stop_q(t2_stop),
    .count_q(t2_count)
  );

  // edge detection on the channel waves
  logic [1:0] wave_prev_q;
  logic [1:0] ev;

  always_ff @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) wave_prev_q <= 2'h0;
    else if (clk_en) wave_prev_q <= {t2_wave, t1_wave};
  end

  assign ev[0] = irq_event(t1_irq_source_sel, t1_irq_edge_sel,
                           t1_wave & ~wave_prev_q[0],
                           ~t1_wave & wave_prev_q[0], t1_stop);
  assign ev[1] = irq_event(t2_irq_source_sel, t2_irq_edge_sel,
                           t2_wave & ~wave_prev_q[1],
                           ~t2_wave & wave_prev_q[1], t2_stop);

  // sticky status, write one clears, a new event wins
  always_ff @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      irq_stat_q <= 2'h0;
      irq_mask_q <= 2'h0;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      if (bus_wr && wb_adr_i == `TPC_OFS_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~wdat[1:0]) | ev;
      else
        irq_stat_q <= irq_stat_q | ev;
      if (bus_wr && wb_adr_i == `TPC_OFS_IRQ_MASK)
        irq_mask_q <= wdat[1:0];
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // read data, unmapped offsets read zero
  always_ff @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      wb_dat_o <= 32'h0;
    end else if (clk_en && bus_req) begin
      unique case (wb_adr_i)
        `TPC_OFS_T1_CTRL: wb_dat_o <= {24'h0, t1_ctrl_q};
        `TPC_OFS_T1_PRESC: wb_dat_o <= {24'h0, t1_presc_q};
        `TPC_OFS_T2_CTRL: wb_dat_o <= {24'h0, t2_ctrl_q};
        `TPC_OFS_T2_PRESC: wb_dat_o <= {24'h0, t2_presc_q};
        `TPC_OFS_PA_ROUTE: wb_dat_o <= {24'h0, pa_route_q};
        `TPC_OFS_PC_ROUTE: wb_dat_o <= {24'h0, pc_route_q};
        `TPC_OFS_T1_RELOAD: wb_dat_o <= 32'(t1_reload_q);
        `TPC_OFS_T1_COMPARE: wb_dat_o <= 32'(t1_compare_q);
        `TPC_OFS_T2_RELOAD: wb_dat_o <= 32'(t2_reload_q);
        `TPC_OFS_T2_COMPARE: wb_dat_o <= 32'(t2_compare_q);
        `TPC_OFS_IRQ_STAT: wb_dat_o <= {30'h0, irq_stat_q};
        `TPC_OFS_IRQ_MASK: wb_dat_o <= {30'h0, irq_mask_q};
        // run and reset-released state, then counts
        `TPC_OFS_T_STATE: wb_dat_o <= {8'h0, 8'(t2_count), 8'(t1_count),
                                       2'h0, t2_soft_reset_n, t2_run,
                                       2'h0, t1_soft_reset_n, t1_run};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // pin multiplexing, timers float while held in reset
  always_ff @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      porta_pin_out <= 8'h0;
      porta_pin_oe <= 8'h0;
      portc_pin_out <= 4'h0;
      portc_pin_oe <= 4'h0;
      timer_b_wave_out <= 1'b0;
      timer_c_wave_out <= 1'b0;
    end else if (clk_en) begin
      timer_b_wave_out <= t1_wave;
      timer_c_wave_out <= t2_wave;
      porta_pin_out <= gpio_a_out;
      porta_pin_oe <= gpio_a_oe;
      if (porta_pin1_timer_route) begin
        porta_pin_out[1] <= timer_a_pin_out; // R8
        porta_pin_oe[1] <= 1'b1; // R8
      end
      if (porta_pin2_timer_route) begin
        porta_pin_out[2] <= t1_wave; // R8
        porta_pin_oe[2] <= t1_soft_reset_n; // R8
      end
      if (porta_pin3_timer_route) begin
        porta_pin_out[3] <= t2_wave; // R8
        porta_pin_oe[3] <= t2_soft_reset_n; // R8
      end
      // a seven-bit port leaves the top pin undriven
      if (!porta_width_sel) begin
        porta_pin_out[7] <= 1'b0; // R9
        porta_pin_oe[7] <= 1'b0; // R9
      end
      portc_pin_out <= gpio_c_out;
      portc_pin_oe <= gpio_c_oe;
      if (!portc_pin1_gpio_sel) begin
        portc_pin_out[0] <= timer_a_pin_out; // R10
        portc_pin_oe[0] <= 1'b1; // R10
      end
      if (!portc_pin2_gpio_sel) begin
        portc_pin_out[1] <= t1_wave; // R10
        portc_pin_oe[1] <= t1_soft_reset_n; // R10
      end
      if (!portc_pin3_gpio_sel) begin
        portc_pin_out[2] <= t2_wave; // R10
        portc_pin_oe[2] <= t2_soft_reset_n; // R10
      end
      if (!portc_pin4_gpio_sel) begin
        portc_pin_out[3] <= sci_tx_out; // R11
        portc_pin_oe[3] <= 1'b1; // R11
      end
    end
  end
endmodule // tpc_top

/* File: sim/tpc_pin_load.sv */
// port C pin loads: pull-ups hold released pins high
`timescale 1ns/1ns
module tpc_pin_load (
  input wire logic [3:0] portc_pin_out,
  input wire logic [3:0] portc_pin_oe,
  output logic [3:0] portc_level
);
  // a driven pin shows its drive, a released one the pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      portc_level[i] = portc_pin_oe[i] ? portc_pin_out[i] : 1'b1;
    end
  end
endmodule // tpc_pin_load

/* File: sim/tpc_properties.sv */
// checker: bus handshake, pin routing and irq masking
`timescale 1ns/1ns
`include "tpc_cfg.svh"
module tpc_properties (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sci_tx_out,
  input wire logic [3:0] gpio_c_out,
  input wire logic [7:0] gpio_a_oe,
  input wire logic [7:0] porta_pin_oe,
  input wire logic [3:0] portc_pin_out,
  input wire logic [3:0] portc_pin_oe,
  input wire logic timer_b_wave_out,
  input wire logic irq_q
);
  logic [2:0] warm_q; // edges since reset release
  logic [7:0] t1_q; // timer 1 control shadow
  logic [7:0] pa_q; // port A routing shadow
  logic [7:0] pc_q; // port C routing shadow
  logic [7:0] mask_q; // irq mask shadow
  logic ready; // reset flops have settled
  logic wr; // write seen at its ack edge
  assign ready = (warm_q == 3'h7);
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & wb_ack_o;
  // wait out the internal reset release
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) warm_q <= 3'h0;
    else if (!ready) warm_q <= warm_q + 3'h1;
  end
  // shadows trail the design registers by one edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      t1_q <= `TPC_RST_CTRL;
      pa_q <= `TPC_RST_PA;
      pc_q <= `TPC_RST_PC;
      mask_q <= 8'h00;
    end else if (wr) begin
      case (wb_adr_i)
        `TPC_OFS_T1_CTRL: t1_q <= wb_dat_i[7:0] & `TPC_MASK_CTRL;
        `TPC_OFS_PA_ROUTE: pa_q <= wb_dat_i[7:0] & `TPC_MASK_ROUTE;
        `TPC_OFS_PC_ROUTE: pc_q <= wb_dat_i[7:0] & `TPC_MASK_ROUTE;
        `TPC_OFS_IRQ_MASK: mask_q <= wb_dat_i[7:0] & `TPC_MASK_IRQ;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // request taken while the slave is idle
  sequence seq_req_taken;
    ready && wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // one-cycle acknowledge
  sequence seq_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_ack_answer: assert property (seq_req_taken |=> seq_ack_pulse)
    else $error("ack missing or too long");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i))
    else $error("ack without a request");
  chk_unmapped_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i > 8'h33 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_ctrl_readback: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == `TPC_OFS_T1_CTRL
    |-> wb_dat_o == {24'h0, t1_q})
    else $error("control read back wrong");
  chk_serial_route: assert property (ready |->
    portc_pin_out[3] == (pc_q[3] ? $past(gpio_c_out[3]) : $past(sci_tx_out))
    && (pc_q[3] || portc_pin_oe[3]))
    else $error("serial pin route wrong");
  chk_timer_route: assert property (ready && !pc_q[1] |->
    portc_pin_oe[1] == t1_q[0]
    && (!t1_q[0] || portc_pin_out[1] == timer_b_wave_out))
    else $error("timer pin route wrong");
  chk_porta_width: assert property (ready |->
    porta_pin_oe[7] == (pa_q[3] & $past(gpio_a_oe[7])))
    else $error("port A width wrong");
  chk_irq_masked: assert property (ready && mask_q == 8'h00 [*2] |-> !irq_q)
    else $error("masked irq raised");
endmodule // tpc_properties

bind tpc_top tpc_properties chk_i (.*);

/* File: sim/tpc_top_test.sv */
// self-checking bench for the timer/pwm configuration block
`timescale 1ns/1ns
`include "tpc_cfg.svh"
module tpc_top_test;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1; // clock enable held on
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic timer_a_pin_out = 1'b0;
  logic sci_tx_out = 1'b1;
  logic [7:0] gpio_a_out = 8'h00;
  logic [7:0] gpio_a_oe = 8'h00;
  logic [3:0] gpio_c_out = 4'h0;
  logic [3:0] gpio_c_oe = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, timer_b_wave_out, timer_c_wave_out, irq_q, wave_v;
  logic [7:0] porta_pin_out, porta_pin_oe, v;
  logic [3:0] portc_pin_out, portc_pin_oe, portc_level;
  logic [3:0] sel_v = 4'hf; // byte select of the next access
  logic ch_v = 1'b0; // measured channel
  logic [31:0] rnd = 32'h9d4dc6d7; // random state
  logic [31:0] rd; // last read data
  logic [7:0] ofs [6] = '{`TPC_OFS_T1_CTRL, `TPC_OFS_T1_PRESC,
    `TPC_OFS_T2_CTRL, `TPC_OFS_T2_PRESC, `TPC_OFS_PA_ROUTE, `TPC_OFS_PC_ROUTE};
  logic [7:0] rstv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f};
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc_cnt = 0;
  int n, base, code;
  assign wave_v = ch_v ? timer_c_wave_out : timer_b_wave_out;
  tpc_top uut (.*);
  tpc_pin_load load_i (.*);
  always #5 ref_clk = ~ref_clk;
  // cut a hang short
  always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 50000) begin
      error_cnt++;
      test_done();
    end
  end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected read back of config register i
  function automatic logic [7:0] masked(int i, logic [7:0] d);
    if (i > 3) return d & `TPC_MASK_ROUTE;
    return d & ((i % 2 == 0) ? `TPC_MASK_CTRL : `TPC_MASK_PRESC);
  endfunction
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one classic wishbone cycle, held until ack
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    rnd = lfsr(rnd);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= sel_v;
    wb_dat_i <= {rnd[31:8], d};
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(logic [7:0] a, logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(rd, {24'h0, e});
  endtask
  // length in cycles of the next phase at level lvl
  task automatic measure(logic lvl, output int len);
    len = 0;
    while (wave_v === lvl) @(posedge ref_clk);
    while (wave_v !== lvl) @(posedge ref_clk);
    while (wave_v === lvl) begin
      @(posedge ref_clk);
      len++;
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    // reset values, then random writes read back through the masks
    for (int i = 0; i < 6; i++) rdc(ofs[i], rstv[i]);
    for (int k = 0; k < 24; k++) begin
      v = lfsr(rnd) >> 3;
      wr(ofs[k % 6], v);
      rdc(ofs[k % 6], masked(k % 6, v));
    end
    // disabled byte lane and unmapped address
    wr(`TPC_OFS_T1_PRESC, 8'h03);
    sel_v = 4'he;
    wr(`TPC_OFS_T1_PRESC, 8'h21);
    sel_v = 4'hf;
    rdc(`TPC_OFS_T1_PRESC, 8'h03);
    wr(8'h3c, 8'hff);
    rdc(8'h3c, 8'h00);
    // port C: serial output routed, then all pins general purpose
    wr(`TPC_OFS_PC_ROUTE, 8'h07);
    for (int k = 0; k < 16; k++) begin
      if (k == 8) wr(`TPC_OFS_PC_ROUTE, 8'h0f);
      rnd = lfsr(rnd);
      sci_tx_out <= rnd[0];
      gpio_c_out <= rnd[4:1];
      gpio_c_oe <= rnd[8:5];
      repeat (3) @(posedge ref_clk);
      if (k < 8) check(portc_level[3], sci_tx_out);
      else check(portc_level, 4'((gpio_c_out & gpio_c_oe) | ~gpio_c_oe));
    end
    // port A width and first timer route
    gpio_a_oe <= 8'hff;
    timer_a_pin_out <= 1'b1;
    wr(`TPC_OFS_PA_ROUTE, 8'h00);
    check(porta_pin_oe[7], 1'b0);
    check(porta_pin_out, 8'h00);
    wr(`TPC_OFS_PA_ROUTE, 8'h09);
    check(porta_pin_oe[7], 1'b1);
    check(porta_pin_out != 8'h00, 1'b1);
    // divider codes scale the square wave by powers of two
    wr(`TPC_OFS_T1_RELOAD, 8'h00);
    wr(`TPC_OFS_T1_COMPARE, 8'h03);
    for (int j = 0; j < 3; j++) begin
      code = (j == 2) ? 3 : j;
      wr(`TPC_OFS_T1_CTRL, 8'h00);
      wr(`TPC_OFS_T1_PRESC, 8'h20 | 8'(code));
      wr(`TPC_OFS_T1_CTRL, 8'h05);
      measure(1'b1, n);
      if (code == 0) base = n;
      else check(n, base << code);
    end
    wr(`TPC_OFS_T1_PRESC, 8'h00);
    measure(1'b1, n);
    check(n, 1);
    // second channel: reset, run, pwm duty and stop
    ch_v = 1'b1;
    wr(`TPC_OFS_T2_RELOAD, 8'h00);
    wr(`TPC_OFS_T2_COMPARE, 8'h10);
    wr(`TPC_OFS_T2_PRESC, 8'h00);
    wr(`TPC_OFS_T2_CTRL, 8'h01);
    bus(1'b0, `TPC_OFS_T_STATE, 8'h00);
    check(rd[5:4], 2'h2);
    wr(`TPC_OFS_T2_CTRL, 8'h85);
    bus(1'b0, `TPC_OFS_T_STATE, 8'h00);
    check(rd[5:4], 2'h3);
    measure(1'b1, n);
    check(n, 16);
    measure(1'b0, n);
    check(n, 256 - 16);
    wr(`TPC_OFS_T2_CTRL, 8'h81);
    bus(1'b0, `TPC_OFS_T_STATE, 8'h00);
    v = rd[23:16];
    repeat (20) @(posedge ref_clk);
    bus(1'b0, `TPC_OFS_T_STATE, 8'h00);
    check(rd[23:16], v);
    // edge interrupt codes with the mask closed
    ch_v = 1'b0;
    wr(`TPC_OFS_IRQ_MASK, 8'h00);
    for (int e = 0; e < 4; e++) begin
      wr(`TPC_OFS_T1_CTRL, 8'h00);
      wr(`TPC_OFS_IRQ_STAT, 8'h03);
      wr(`TPC_OFS_T1_CTRL, 8'h45 | 8'(e << 4));
      repeat (20) @(posedge ref_clk);
      bus(1'b0, `TPC_OFS_IRQ_STAT, 8'h00);
      check(rd[0], e != 3);
    end
    // stop interrupt, then mask and clear
    wr(`TPC_OFS_T1_CTRL, 8'h05);
    wr(`TPC_OFS_IRQ_STAT, 8'h03);
    bus(1'b0, `TPC_OFS_IRQ_STAT, 8'h00);
    check(rd[0], 1'b0);
    wr(`TPC_OFS_T1_CTRL, 8'h01);
    bus(1'b0, `TPC_OFS_IRQ_STAT, 8'h00);
    check(rd[0], 1'b1);
    check(irq_q, 1'b0);
    wr(`TPC_OFS_IRQ_MASK, 8'h01);
    check(irq_q, 1'b1);
    wr(`TPC_OFS_IRQ_STAT, 8'h01);
    repeat (2) @(posedge ref_clk);
    check(irq_q, 1'b0);
    test_done();
  end
endmodule // tpc_top_test
